//--- hw/rpaw_top.sv
// Pipe 2..5 receive address bytes, transmit address, pipe 0..2 widths.
// Assumes AHB-Lite word access and pipe 1 upper bytes from outside.
//
// Overview of operation
// - Pipes 2 to 5 each hold a low address byte, reset C3..C6.
// - Pipes 2 to 5 take upper address bytes 39:8 from pipe 1.
// - A 40-bit transmit address exists, used only as primary transmitter.
// - Pipes 0 to 2 each have a 6-bit payload width; 0 unused, 1 to 32 bytes.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module rpaw_top (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic [31:0] i_rx_pipe1_upper,
  input  wire logic        i_primary_transmitter_role,
  output logic [39:0]      o_rx_pipe2_address,
  output logic [39:0]      o_rx_pipe3_address,
  output logic [39:0]      o_rx_pipe4_address,
  output logic [39:0]      o_rx_pipe5_address,
  output logic [39:0]      o_transmit_address,
  output logic             o_tx_address_active,
  output logic [5:0]       o_rx_pipe0_payload_width,
  output logic [5:0]       o_rx_pipe1_payload_width,
  output logic [5:0]       o_rx_pipe2_payload_width,
  output logic [2:0]       o_pipe_in_use
);

  rpaw_reg_if rif ();

  rpaw_ahb_slave u_slave (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .o_hrdata    (o_hrdata),
    .rif         (rif)
  );

  logic [7:0]  rx_low_r   [rpaw_pkg::NUM_LOW];
  logic [7:0]  rx_low_nxt [rpaw_pkg::NUM_LOW];
  logic [5:0]  pw_r       [rpaw_pkg::NUM_PW];
  logic [5:0]  pw_nxt     [rpaw_pkg::NUM_PW];
  logic [39:0] txa_r;
  logic [39:0] txa_nxt;

  // Replaces one byte only when its lane is enabled
  function automatic logic [7:0] merge8(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic       en);
    merge8 = en ? new_v : old_v;
  endfunction

  // A width counts as in use only within 1..32; larger values are kept
  // as written but never enable the pipe
  function automatic logic width_in_use(input logic [5:0] w);
    width_in_use = (w != 6'h00) && (w <= rpaw_pkg::PW_MAX);
  endfunction

  always_comb begin
    for (int i = 0; i < rpaw_pkg::NUM_LOW; i++) begin
      rx_low_nxt[i] = rx_low_r[i];
    end
    for (int i = 0; i < rpaw_pkg::NUM_PW; i++) begin
      pw_nxt[i] = pw_r[i];
    end
    txa_nxt = txa_r;
    if (rif.wr_en) begin
      unique case (rif.idx)
        rpaw_pkg::IDX_RX2_LOW: begin
          rx_low_nxt[0] = merge8(rx_low_r[0], rif.wdata[7:0],
                                 rif.be[0]);
        end
        rpaw_pkg::IDX_RX3_LOW: begin
          rx_low_nxt[1] = merge8(rx_low_r[1], rif.wdata[7:0],
                                 rif.be[0]);
        end
        rpaw_pkg::IDX_RX4_LOW: begin
          rx_low_nxt[2] = merge8(rx_low_r[2], rif.wdata[7:0],
                                 rif.be[0]);
        end
        rpaw_pkg::IDX_RX5_LOW: begin
          rx_low_nxt[3] = merge8(rx_low_r[3], rif.wdata[7:0],
                                 rif.be[0]);
        end
        rpaw_pkg::IDX_TXA: begin
          // Lane 0 carries the least significant address byte
          for (int b = 0; b < 4; b++) begin
            txa_nxt[b*8 +: 8] = merge8(txa_r[b*8 +: 8],
                                       rif.wdata[b*8 +: 8],
                                       rif.be[b]);
          end
        end
        rpaw_pkg::IDX_TXA_HI: begin
          txa_nxt[39:32] = merge8(txa_r[39:32], rif.wdata[7:0],
                                  rif.be[0]);
        end
        rpaw_pkg::IDX_PW0: begin
          // Bits 7:6 are fixed at zero, so only the field is taken
          if (rif.be[0]) begin
            pw_nxt[0] = rif.wdata[rpaw_pkg::PW_LSB +: rpaw_pkg::PW_W];
          end
        end
        rpaw_pkg::IDX_PW1: begin
          if (rif.be[0]) begin
            pw_nxt[1] = rif.wdata[rpaw_pkg::PW_LSB +: rpaw_pkg::PW_W];
          end
        end
        rpaw_pkg::IDX_PW2: begin
          if (rif.be[0]) begin
            pw_nxt[2] = rif.wdata[rpaw_pkg::PW_LSB +: rpaw_pkg::PW_W];
          end
        end
        // Unmapped writes are dropped; the bus still answers OKAY
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_low_r[0] <= rpaw_pkg::RST_RX2_LOW;
      rx_low_r[1] <= rpaw_pkg::RST_RX3_LOW;
      rx_low_r[2] <= rpaw_pkg::RST_RX4_LOW;
      rx_low_r[3] <= rpaw_pkg::RST_RX5_LOW;
      for (int i = 0; i < rpaw_pkg::NUM_PW; i++) begin
        pw_r[i] <= rpaw_pkg::RST_PW;
      end
      txa_r <= rpaw_pkg::RST_TXA;
    end else begin
      for (int i = 0; i < rpaw_pkg::NUM_LOW; i++) begin
        rx_low_r[i] <= rx_low_nxt[i];
      end
      for (int i = 0; i < rpaw_pkg::NUM_PW; i++) begin
        pw_r[i] <= pw_nxt[i];
      end
      txa_r <= txa_nxt;
    end
  end

  // Read mux; narrow registers sit in the low bits, the rest reads zero
  always_comb begin
    rif.rdata = 32'h0000_0000;
    unique case (rif.idx)
      rpaw_pkg::IDX_RX2_LOW: rif.rdata[7:0] = rx_low_r[0];
      rpaw_pkg::IDX_RX3_LOW: rif.rdata[7:0] = rx_low_r[1];
      rpaw_pkg::IDX_RX4_LOW: rif.rdata[7:0] = rx_low_r[2];
      rpaw_pkg::IDX_RX5_LOW: rif.rdata[7:0] = rx_low_r[3];
      rpaw_pkg::IDX_TXA:     rif.rdata = txa_r[31:0];
      rpaw_pkg::IDX_TXA_HI:  rif.rdata[7:0] = txa_r[39:32];
      rpaw_pkg::IDX_PW0:     rif.rdata[5:0] = pw_r[0];
      rpaw_pkg::IDX_PW1:     rif.rdata[5:0] = pw_r[1];
      rpaw_pkg::IDX_PW2:     rif.rdata[5:0] = pw_r[2];
      default: begin
      end
    endcase
  end

  // Pipes 2..5 share pipe 1's upper bytes, so one write to pipe 1
  // retargets all four at once
  assign o_rx_pipe2_address = {i_rx_pipe1_upper, rx_low_r[0]};
  assign o_rx_pipe3_address = {i_rx_pipe1_upper, rx_low_r[1]};
  assign o_rx_pipe4_address = {i_rx_pipe1_upper, rx_low_r[2]};
  assign o_rx_pipe5_address = {i_rx_pipe1_upper, rx_low_r[3]};

  // Matching pipe 0 to this address is left to software
  assign o_transmit_address  = txa_r;
  assign o_tx_address_active = i_primary_transmitter_role;

  assign o_rx_pipe0_payload_width = pw_r[0];
  assign o_rx_pipe1_payload_width = pw_r[1];
  assign o_rx_pipe2_payload_width = pw_r[2];
  assign o_pipe_in_use = {width_in_use(pw_r[2]),
                          width_in_use(pw_r[1]),
                          width_in_use(pw_r[0])};

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // Checked at the first edge after release, when reset is no longer seen
  AST_RX_RESET: assert property (
    $fell(i_reset) |-> rx_low_r[0] == rpaw_pkg::RST_RX2_LOW &&
      rx_low_r[3] == rpaw_pkg::RST_RX5_LOW)
    else $error("Pipe low address bytes not at reset values");

  AST_RX_WRITE: assert property (
    rif.wr_en && rif.idx == rpaw_pkg::IDX_RX3_LOW && rif.be[0]
    |=> rx_low_r[1] == $past(rif.wdata[7:0]))
    else $error("Pipe 3 low byte write not stored");

  AST_PIPE_UPPER: assert property (
    !(rif.wr_en && rif.idx == rpaw_pkg::IDX_RX4_LOW)
    |=> ($stable(i_rx_pipe1_upper) |-> $stable(o_rx_pipe4_address)))
    else $error("Pipe 4 address moved without a write or upper change");

  AST_TXA_LANE: assert property (
    rif.wr_en && rif.idx == rpaw_pkg::IDX_TXA && !rif.be[2]
    |=> txa_r[23:16] == $past(txa_r[23:16]))
    else $error("Unwritten transmit address byte changed");

  AST_TXA_HOLD: assert property (
    !(rif.wr_en && (rif.idx == rpaw_pkg::IDX_TXA ||
                    rif.idx == rpaw_pkg::IDX_TXA_HI))
    |=> $stable(txa_r))
    else $error("Transmit address changed without a write");

  AST_PW_UNUSED: assert property (
    rif.wr_en && rif.idx == rpaw_pkg::IDX_PW0 && rif.be[0] &&
    rif.wdata[5:0] == 6'h00 |=> !o_pipe_in_use[0])
    else $error("Pipe 0 in use with zero payload width");

  AST_PW_READ: assert property (
    rif.rd_req && rif.idx == rpaw_pkg::IDX_PW2
    |-> rif.rdata == {26'h0, pw_r[2]})
    else $error("Payload width read shows nonzero upper bits");

  COV_RX_WRITE: cover property (
    rif.wr_en && rif.idx == rpaw_pkg::IDX_RX2_LOW);
  COV_TXA_FULL: cover property (
    rif.wr_en && rif.idx == rpaw_pkg::IDX_TXA ##[1:20]
    rif.wr_en && rif.idx == rpaw_pkg::IDX_TXA_HI);
  COV_PW_IN_USE: cover property (o_pipe_in_use == 3'h7);

endmodule
`default_nettype wire

//--- hw/rpaw_pkg.sv
// Constants and types for the pipe address and payload width registers.
// Assumes AHB-Lite word access; register index = byte address / 4.
package rpaw_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_RX2_LOW = 8'h0c;
  localparam logic [7:0] IDX_RX3_LOW = 8'h0d;
  localparam logic [7:0] IDX_RX4_LOW = 8'h0e;
  localparam logic [7:0] IDX_RX5_LOW = 8'h0f;
  localparam logic [7:0] IDX_TXA     = 8'h10;
  localparam logic [7:0] IDX_PW0     = 8'h11;
  localparam logic [7:0] IDX_PW1     = 8'h12;
  localparam logic [7:0] IDX_PW2     = 8'h13;
  // Holds transmit address bits 39:32, which do not fit the word above
  localparam logic [7:0] IDX_TXA_HI  = 8'h20;

  localparam int IDX_LSB = 2;
  localparam int IDX_W   = 8;

  localparam int ADDR_W  = 40;
  localparam int BYTE_W  = 8;
  localparam int NUM_LOW = 4;
  localparam int NUM_PW  = 3;
  localparam int PW_LSB  = 0;
  localparam int PW_W    = 6;

  localparam logic [7:0]  RST_RX2_LOW = 8'hc3;
  localparam logic [7:0]  RST_RX3_LOW = 8'hc4;
  localparam logic [7:0]  RST_RX4_LOW = 8'hc5;
  localparam logic [7:0]  RST_RX5_LOW = 8'hc6;
  localparam logic [39:0] RST_TXA     = 40'he7e7e7e7e7;
  localparam logic [5:0]  RST_PW      = 6'h00;
  localparam logic [5:0]  PW_MAX      = 6'h20;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] HSIZE_HALF    = 3'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR   = 4'b0010,
    ST_RDW  = 4'b0100,
    ST_RDD  = 4'b1000
  } rpaw_ahb_st_t;

endpackage

//--- hw/rpaw_reg_if.sv
// Register access strobes between the bus slave and the register bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface rpaw_reg_if;
  logic        wr_en;
  logic        rd_req;
  logic [7:0]  idx;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport bus  (output wr_en, rd_req, idx, be, wdata, input rdata);
  modport regs (input wr_en, rd_req, idx, be, wdata, output rdata);
endinterface
`default_nettype wire

//--- hw/rpaw_ahb_slave.sv
// AHB-Lite slave front end: turns bus transfers into register strobes.
// Assumes a single master; writes take no wait state, reads take one.
`timescale 1ns/100ps
`default_nettype none
module rpaw_ahb_slave (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  rpaw_reg_if.bus          rif
);

  rpaw_pkg::rpaw_ahb_st_t st_r, st_nxt;
  logic [7:0]  idx_r, idx_nxt;
  logic [3:0]  be_r, be_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        accept;

  assign accept = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    be_nxt    = be_r;
    rdata_nxt = rdata_r;
    unique case (st_r)
      rpaw_pkg::ST_RDW: begin
        // Sampled one cycle late so a write just before is seen
        rdata_nxt = rif.rdata;
        st_nxt    = rpaw_pkg::ST_RDD;
      end
      default: begin
        st_nxt = rpaw_pkg::ST_IDLE;
        if (accept) begin
          idx_nxt = i_haddr[rpaw_pkg::IDX_LSB +: rpaw_pkg::IDX_W];
          st_nxt  = i_hwrite ? rpaw_pkg::ST_WR : rpaw_pkg::ST_RDW;
          if (i_hsize == rpaw_pkg::HSIZE_BYTE)
            be_nxt = 4'h1 << i_haddr[1:0];
          else if (i_hsize == rpaw_pkg::HSIZE_HALF)
            be_nxt = i_haddr[1] ? 4'hc : 4'h3;
          else
            be_nxt = 4'hf;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r    <= rpaw_pkg::ST_IDLE;
      idx_r   <= 8'h00;
      be_r    <= 4'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      be_r    <= be_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rif.wr_en  = (st_r == rpaw_pkg::ST_WR);
  assign rif.rd_req = (st_r == rpaw_pkg::ST_RDW);
  assign rif.idx    = idx_r;
  assign rif.be     = be_r;
  assign rif.wdata  = i_hwdata;

  assign o_hreadyout = (st_r != rpaw_pkg::ST_RDW);
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_r;

  AST_RD_ONE_WAIT: assert property (@(posedge i_clk)
    disable iff (i_reset)
    accept && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("Read did not answer after exactly one wait state");

  AST_RD_DATA: assert property (@(posedge i_clk)
    disable iff (i_reset)
    rif.rd_req |=> o_hrdata == $past(rif.rdata))
    else $error("Read data does not match stored register value");

endmodule
`default_nettype wire

//--- tb/tb_radio_pipe_address_width_regs.sv
// Self-checking bench for the pipe address and payload width registers.
// Assumes rpaw_top alone on a single-master AHB-Lite bus, 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_radio_pipe_address_width_regs;
  logic        i_clk;
  logic        i_reset;
  logic        i_hsel;
  logic [31:0] i_haddr;
  logic [1:0]  i_htrans;
  logic        i_hwrite;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic [31:0] o_hrdata;
  logic [31:0] i_rx_pipe1_upper;
  logic        i_primary_transmitter_role;
  logic [39:0] o_p2;
  logic [39:0] o_p3;
  logic [39:0] o_p4;
  logic [39:0] o_p5;
  logic [39:0] o_txa;
  logic        o_txa_act;
  logic [5:0]  o_w0;
  logic [5:0]  o_w1;
  logic [5:0]  o_w2;
  logic [2:0]  o_in_use;
  int          err_count;
  int          num_checks;
  logic [31:0] rd;
  logic [2:0]  xsize;
  // Byte address, write value, reset read value, read-back after write
  localparam logic [31:0] ADR [9] = '{32'h30, 32'h34, 32'h38, 32'h3c,
    32'h40, 32'h44, 32'h48, 32'h4c, 32'h80};
  localparam logic [31:0] WRV [9] = '{32'h1234565a, 32'h01, 32'hffffff00,
    32'hff, 32'h89abcdef, 32'hffffffe0, 32'h01, 32'h21, 32'h00000f12};
  localparam logic [31:0] RSV [9] = '{32'hc3, 32'hc4, 32'hc5, 32'hc6,
    32'he7e7e7e7, 32'h0, 32'h0, 32'h0, 32'he7};
  localparam logic [31:0] RBV [9] = '{32'h5a, 32'h01, 32'h00, 32'hff,
    32'h89abcdef, 32'h20, 32'h01, 32'h21, 32'h12};

  rpaw_top dut (
    .i_clk                      (i_clk),
    .i_reset                    (i_reset),
    .i_hsel                     (i_hsel),
    .i_haddr                    (i_haddr),
    .i_htrans                   (i_htrans),
    .i_hwrite                   (i_hwrite),
    .i_hsize                    (i_hsize),
    .i_hwdata                   (i_hwdata),
    .i_hready                   (o_hreadyout),
    .o_hreadyout                (o_hreadyout),
    .o_hresp                    (o_hresp),
    .o_hrdata                   (o_hrdata),
    .i_rx_pipe1_upper           (i_rx_pipe1_upper),
    .i_primary_transmitter_role (i_primary_transmitter_role),
    .o_rx_pipe2_address         (o_p2),
    .o_rx_pipe3_address         (o_p3),
    .o_rx_pipe4_address         (o_p4),
    .o_rx_pipe5_address         (o_p5),
    .o_transmit_address         (o_txa),
    .o_tx_address_active        (o_txa_act),
    .o_rx_pipe0_payload_width   (o_w0),
    .o_rx_pipe1_payload_width   (o_w1),
    .o_rx_pipe2_payload_width   (o_w2),
    .o_pipe_in_use              (o_in_use)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [39:0] seen,
                       input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sampling at the falling edge sees what the next rising edge samples,
  // without racing the design's own flop updates.
  task automatic wait_ready(output logic [31:0] d);
    int   n;
    logic r;
    n = 0;
    r = 1'b0;
    d = '0;
    while (r !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      r = o_hreadyout;
      d = o_hrdata;
      check("hresp", 40'(o_hresp), 40'h0);
      @(posedge i_clk);
      n++;
    end
    check("hready", 40'(r), 40'h1);
  endtask

  task automatic bus_xfer(input logic [31:0] a, input logic wr,
                          input logic [31:0] wd, output logic [31:0] d);
    logic [31:0] dummy;
    i_haddr  <= a;
    i_hwrite <= wr;
    i_htrans <= 2'h2;
    i_hsize  <= xsize;
    wait_ready(dummy);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_ready(d);
  endtask

  task automatic check_resets();
    for (int k = 0; k < 9; k++) begin
      bus_xfer(ADR[k], 1'b0, 32'h0, rd);
      check("reset read", 40'(rd), 40'(RSV[k]));
    end
    check("tx reset", o_txa, 40'he7e7e7e7e7);
    check("in use reset", 40'(o_in_use), 40'h0);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    close_out();
  end

  initial begin
    err_count = 0;
    num_checks = 0;
    xsize = 3'h2;
    i_reset = 1'b1;
    i_hsel = 1'b1;
    i_haddr = '0;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = '0;
    i_rx_pipe1_upper = 32'hdeadbe01;
    i_primary_transmitter_role = 1'b0;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    check_resets();
    // Each write is followed at once by its read-back
    for (int k = 0; k < 9; k++) begin
      bus_xfer(ADR[k], 1'b1, WRV[k], rd);
      bus_xfer(ADR[k], 1'b0, 32'h0, rd);
      check("readback", 40'(rd), 40'(RBV[k]));
    end
    check("pipe2 addr", o_p2, 40'hdeadbe015a);
    check("pipe3 addr", o_p3, 40'hdeadbe0101);
    check("pipe4 addr", o_p4, 40'hdeadbe0100);
    check("pipe5 addr", o_p5, 40'hdeadbe01ff);
    check("tx addr", o_txa, 40'h1289abcdef);
    check("width0", 40'(o_w0), 40'h20);
    check("width1", 40'(o_w1), 40'h01);
    check("width2", 40'(o_w2), 40'h21);
    check("in use", 40'(o_in_use), 40'h3);
    // Upper bytes follow pipe 1 with the low bytes kept
    i_rx_pipe1_upper <= 32'h0102a3f4;
    @(posedge i_clk);
    @(negedge i_clk);
    check("pipe5 follow", o_p5, 40'h0102a3f4ff);
    check("pipe2 follow", o_p2, 40'h0102a3f45a);
    // Low word first, then high word; rewriting low keeps high bits
    bus_xfer(32'h40, 1'b1, 32'h00000011, rd);
    bus_xfer(32'h80, 1'b1, 32'h00000055, rd);
    bus_xfer(32'h40, 1'b1, 32'h44332211, rd);
    @(negedge i_clk);
    check("tx lsb first", o_txa, 40'h5544332211);
    // Software copies this word into pipe 0 for acknowledgements
    @(posedge i_clk);
    bus_xfer(32'h40, 1'b0, 32'h0, rd);
    check("tx copy", 40'(rd), 40'h44332211);
    // Role only gates use of the address, never its value
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_primary_transmitter_role <= k[0];
      @(negedge i_clk);
      check("role", 40'(o_txa_act), 40'(k[0]));
      check("tx hold", o_txa, 40'h5544332211);
    end
    @(posedge i_clk);
    // A byte write to lane 1 leaves the other address bytes alone
    xsize = 3'h0;
    bus_xfer(32'h41, 1'b1, 32'h0000aa00, rd);
    xsize = 3'h2;
    @(negedge i_clk);
    check("tx byte lane", o_txa, 40'h554433aa11);
    @(posedge i_clk);
    // Width 0 falls just below the in-use range and 32 is its top edge
    bus_xfer(32'h44, 1'b1, 32'h0, rd);
    bus_xfer(32'h4c, 1'b1, 32'h20, rd);
    @(negedge i_clk);
    check("in use edges", 40'(o_in_use), 40'h6);
    @(posedge i_clk);
    // Unmapped word: write dropped, read zero
    bus_xfer(32'h50, 1'b1, 32'hffffffff, rd);
    bus_xfer(32'h50, 1'b0, 32'h0, rd);
    check("unmapped", 40'(rd), 40'h0);
    bus_xfer(32'h30, 1'b0, 32'h0, rd);
    check("unmapped side", 40'(rd), 40'h5a);
    // Second reset in mid-run brings every register back
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    check_resets();
    close_out();
  end
endmodule
`default_nettype wire
